// *** rtl/byte_fifo.v ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap only for a power-of-two depth
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// *** rtl/isp_node.v ***
// Session, programming and readout handler of a CAN in-system programming node
`timescale 1ns/100ps
`include "isp_node_regs.vh"

module isp_node #(
  parameter FIFO_DEPTH = `FIFO_WORDS
) (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire [7:0]  node_number,
  input  wire [7:0]  identifier_base,
  input  wire [7:0]  loader_version,
  input  wire        prog_protect,
  input  wire        read_protect,
  input  wire        rx_valid,
  output reg         rx_ready,
  input  wire [10:0] rx_id,
  input  wire [3:0]  rx_dlc,
  input  wire [63:0] rx_data,
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg  [10:0] tx_id,
  output reg  [3:0]  tx_dlc,
  output reg  [63:0] tx_data,
  output reg         mem_req,
  output reg         mem_we,
  output reg         mem_area,
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg         mem_page_last,
  input  wire        mem_ack,
  input  wire        mem_err,
  input  wire [7:0]  mem_rdata,
  output reg         session_open
);
  localparam S_IDLE  = 3'd0;
  localparam S_PUSH  = 3'd1;
  localparam S_DRAIN = 3'd2;
  localparam S_READ  = 3'd3;
  localparam S_SEND  = 3'd4;

  reg  [2:0]  state;
  reg         armed;
  reg         blank;
  reg         more;
  reg         last_done;
  reg         fail;
  reg  [15:0] addr;
  reg  [15:0] end_addr;
  reg  [63:0] rx_buf;
  reg  [3:0]  rx_cnt;
  reg  [2:0]  byte_idx;
  wire        push_valid;
  wire        push_ready;
  wire        fifo_valid;
  wire        fifo_pop;
  wire [7:0]  fifo_data;
  wire        writing;
  wire        in_group;
  wire [3:0]  rx_ofs;
  wire        take;

  function [10:0] msg_id;
    input [7:0] base;
    input [3:0] ofs;
    begin
      msg_id = {base[6:0], ofs};
    end
  endfunction

  // take base as its low seven bits; bit 7 is ignored
  assign in_group   = (rx_id[10:4] == identifier_base[6:0]);
  assign rx_ofs     = rx_id[3:0];
  assign take       = rx_valid & rx_ready;
  assign writing    = (state == S_PUSH) || (state == S_DRAIN);
  assign push_valid = (state == S_PUSH) && (rx_cnt != 4'h0);
  // Bytes past the end of the range are discarded, not written
  assign fifo_pop   = writing & ((mem_req & mem_we & mem_ack) | (last_done & fifo_valid & !mem_req));

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (rx_buf[7:0]),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state         <= S_IDLE;
      rx_ready      <= 1'b0;
      tx_valid      <= 1'b0;
      tx_id         <= 11'h000;
      tx_dlc        <= 4'h0;
      tx_data       <= 64'h0000_0000_0000_0000;
      mem_req       <= 1'b0;
      mem_we        <= 1'b0;
      mem_area      <= 1'b0;
      mem_addr      <= 16'h0000;
      mem_wdata     <= 8'h00;
      mem_page_last <= 1'b0;
      session_open  <= 1'b0;
      armed         <= 1'b0;
      blank         <= 1'b0;
      more          <= 1'b0;
      last_done     <= 1'b0;
      fail          <= 1'b0;
      addr          <= 16'h0000;
      end_addr      <= 16'h0000;
      rx_buf        <= 64'h0000_0000_0000_0000;
      rx_cnt        <= 4'h0;
      byte_idx      <= 3'd0;
    end else begin
      case (state)
        S_IDLE: begin
          rx_ready <= 1'b1;
          // standard frames of at most eight bytes
          if (take && in_group && rx_dlc <= `MAX_DLC) begin
            if (rx_ofs == `OFS_NODE_SELECT && rx_dlc != 4'h0 &&
                (rx_data[7:0] == `NODE_BROADCAST || rx_data[7:0] == node_number)) begin
              session_open <= !session_open;
              armed        <= 1'b0;
              rx_ready     <= 1'b0;
              tx_id        <= msg_id(identifier_base, `OFS_NODE_SELECT);
              tx_dlc       <= 4'h2;
              tx_data      <= {48'h0000_0000_0000,
                               (session_open ? `SESSION_CLOSED : `SESSION_OPEN), loader_version};
              tx_valid     <= 1'b1;
              state        <= S_SEND;
            end else if (session_open && rx_ofs == `OFS_PROG_START && rx_dlc == `START_DLC) begin
              rx_ready <= 1'b0;
              tx_valid <= 1'b1;
              state    <= S_SEND;
              if (prog_protect) begin
                armed   <= 1'b0;
                tx_id   <= msg_id(identifier_base, `OFS_ERROR_REPORT);
                tx_dlc  <= 4'h1;
                tx_data <= {56'h00_0000_0000_0000, `ERROR_CODE};
              end else begin
                armed     <= 1'b1;
                last_done <= 1'b0;
                fail      <= 1'b0;
                mem_area  <= (rx_data[7:0] == `AREA_EEPROM);
                addr      <= {rx_data[15:8], rx_data[23:16]};
                end_addr  <= {rx_data[31:24], rx_data[39:32]};
                tx_id     <= msg_id(identifier_base, `OFS_PROG_START);
                tx_dlc    <= 4'h0;
                tx_data   <= 64'h0000_0000_0000_0000;
              end
            // data only after an acknowledged start
            end else if (session_open && armed && rx_ofs == `OFS_PROG_DATA) begin
              rx_ready <= 1'b0;
              rx_buf   <= rx_data;
              rx_cnt   <= rx_dlc;
              state    <= S_PUSH;
            end else if (session_open && rx_ofs == `OFS_READOUT && rx_dlc == `START_DLC) begin
              rx_ready <= 1'b0;
              if (read_protect) begin
                tx_id    <= msg_id(identifier_base, `OFS_ERROR_REPORT);
                tx_dlc   <= 4'h1;
                tx_data  <= {56'h00_0000_0000_0000, `ERROR_CODE};
                tx_valid <= 1'b1;
                more     <= 1'b0;
                state    <= S_SEND;
              end else begin
                armed    <= 1'b0;
                blank    <= (rx_data[7:0] == `RD_BLANK_FLASH);
                mem_area <= (rx_data[7:0] == `RD_SHOW_EEPROM);
                addr     <= {rx_data[15:8], rx_data[23:16]};
                end_addr <= {rx_data[31:24], rx_data[39:32]};
                byte_idx <= 3'd0;
                tx_data  <= 64'h0000_0000_0000_0000;
                state    <= S_READ;
              end
            end
          end
        end
        S_PUSH: begin
          // frame bytes enter the FIFO; a full FIFO stalls them
          if (rx_cnt == 4'h0) begin
            state <= S_DRAIN;
          end else if (push_ready) begin
            rx_buf <= {8'h00, rx_buf[63:8]};
            rx_cnt <= rx_cnt - 4'h1;
          end
        end
        S_DRAIN: begin
          if (!fifo_valid && !mem_req) begin
            tx_id    <= msg_id(identifier_base, `OFS_PROG_DATA);
            tx_dlc   <= 4'h1;
            tx_data  <= {56'h00_0000_0000_0000,
                         (fail ? `RESULT_FAIL : (last_done ? `RESULT_OK : `RESULT_NEW))};
            tx_valid <= 1'b1;
            more     <= 1'b0;
            // disarm after the range end or a failure
            if (fail || last_done) begin
              armed <= 1'b0;
            end
            state <= S_SEND;
          end
        end
        S_READ: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= addr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            addr    <= addr + 16'h0001;
            tx_id   <= msg_id(identifier_base, `OFS_READOUT);
            if (blank) begin
              // first non-erased address or zero length
              if (mem_rdata != `ERASED_BYTE) begin
                tx_dlc   <= 4'h2;
                tx_data  <= {48'h0000_0000_0000, addr[7:0], addr[15:8]};
                tx_valid <= 1'b1;
                more     <= 1'b0;
                state    <= S_SEND;
              end else if (addr == end_addr) begin
                tx_dlc   <= 4'h0;
                tx_valid <= 1'b1;
                more     <= 1'b0;
                state    <= S_SEND;
              end
            end else begin
              // up to eight bytes per frame
              tx_data[byte_idx*8 +: 8] <= mem_rdata;
              byte_idx                 <= byte_idx + 3'd1;
              if (addr == end_addr || byte_idx == 3'd7) begin
                tx_dlc   <= {1'b0, byte_idx} + 4'h1;
                tx_valid <= 1'b1;
                more     <= (addr != end_addr);
                state    <= S_SEND;
              end
            end
          end
        end
        S_SEND: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (more) begin
              byte_idx <= 3'd0;
              tx_data  <= 64'h0000_0000_0000_0000;
              state    <= S_READ;
            end else begin
              rx_ready <= 1'b1;
              state    <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase

      // Write drain runs beside the push so the FIFO really fills
      if (writing) begin
        if (!mem_req && fifo_valid && !last_done) begin
          mem_req       <= 1'b1;
          mem_we        <= 1'b1;
          mem_addr      <= addr;
          mem_wdata     <= fifo_data;
          // close the page at its boundary or at range end
          mem_page_last <= ((addr & `PAGE_MASK) == `PAGE_MASK) || (addr == end_addr);
        end else if (mem_req && mem_ack) begin
          mem_req       <= 1'b0;
          mem_page_last <= 1'b0;
          addr          <= addr + 16'h0001;
          if (mem_err) begin
            fail <= 1'b1;
          end
          if (addr == end_addr) begin
            last_done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // isp_node

// *** rtl/isp_node_regs.vh ***
// Message offsets, codes and sizes for the CAN programming session handler
`ifndef ISP_NODE_REGS_VH
`define ISP_NODE_REGS_VH

// Message offsets from the identifier base
`define OFS_NODE_SELECT   4'h0
`define OFS_PROG_START    4'h1
`define OFS_PROG_DATA     4'h2
`define OFS_READOUT       4'h3
`define OFS_WRITE_CMD     4'h4
`define OFS_READ_CMD      4'h5
`define OFS_ERROR_REPORT  4'h6

// Identifier base is seven bits wide, so its largest value is 7Fh
`define BASE_MAX          8'h7F
`define BASE_RESET        8'h00

`define NODE_BROADCAST    8'hFF
`define SESSION_CLOSED    8'h00
`define SESSION_OPEN      8'h01

`define AREA_FLASH        8'h00
`define AREA_EEPROM       8'h01

`define RD_SHOW_FLASH     8'h00
`define RD_BLANK_FLASH    8'h01
`define RD_SHOW_EEPROM    8'h02

`define RESULT_OK         8'h00
`define RESULT_FAIL       8'h01
`define RESULT_NEW        8'h02

`define ERASED_BYTE       8'hFF
`define ERROR_CODE        8'h00
`define START_DLC         4'h5
`define MAX_DLC           4'h8
`define PAGE_MASK         16'h007F
`define FIFO_WORDS        8

`endif

// *** testbench/isp_node_sva.sv ***
// Port checker for the programming node
`timescale 1ns/100ps
module isp_node_sva (
  input wire        core_clk,
  input wire        rstn,
  input wire [7:0]  node_number,
  input wire [7:0]  identifier_base,
  input wire [7:0]  loader_version,
  input wire        prog_protect,
  input wire        read_protect,
  input wire        rx_valid,
  input wire        rx_ready,
  input wire [10:0] rx_id,
  input wire [3:0]  rx_dlc,
  input wire [63:0] rx_data,
  input wire        tx_valid,
  input wire        tx_ready,
  input wire [10:0] tx_id,
  input wire [3:0]  tx_dlc,
  input wire [63:0] tx_data,
  input wire        mem_req,
  input wire        mem_we,
  input wire [15:0] mem_addr,
  input wire        mem_page_last,
  input wire        mem_ack,
  input wire        session_open
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire [6:0] base7 = identifier_base[6:0];
  wire       take  = rx_valid & rx_ready & (rx_id[10:4] == base7);
  wire [3:0] ofs   = rx_id[3:0];
  wire       sel   = take & (ofs == 4'h0) & (rx_dlc == 4'h1);
  wire       hit   = (rx_data[7:0] == 8'hFF) | (rx_data[7:0] == node_number);
  wire       req5  = take & session_open & (rx_dlc == 4'h5);
  a_closed_ignore: assert property (rx_valid & rx_ready & !session_open & !(take & ofs == 4'h0) |=> rx_ready & !tx_valid)
    else $error("frame acted on without session");
  a_select_answer: assert property (sel & hit |=> tx_valid & tx_id == {base7, 4'h0} & tx_dlc == 4'h2 &
    tx_data[7:0] == loader_version & tx_data[15:8] == {7'h00, session_open})
    else $error("bad select answer");
  a_select_toggle: assert property (sel & hit |=> session_open != $past(session_open))
    else $error("select did not toggle session");
  a_select_foreign: assert property (sel & !hit |=> $stable(session_open) & !tx_valid)
    else $error("foreign select acted on");
  a_start_error: assert property (req5 & ofs == 4'h1 & prog_protect |=>
    tx_valid & tx_id == {base7, 4'h6} & tx_dlc == 4'h1 & tx_data[7:0] == 8'h00)
    else $error("protected start not refused");
  a_start_ack: assert property (req5 & ofs == 4'h1 & !prog_protect |=> tx_valid & tx_id == {base7, 4'h1} & tx_dlc == 4'h0)
    else $error("start not acknowledged");
  a_read_error: assert property (req5 & ofs == 4'h3 & read_protect |=> tx_valid & tx_id == {base7, 4'h6})
    else $error("protected read not refused");
  a_tx_hold: assert property (tx_valid & !tx_ready |=> tx_valid & $stable(tx_id) & $stable(tx_dlc) & $stable(tx_data))
    else $error("answer changed before taken");
  a_tx_frame: assert property (tx_valid |-> tx_dlc <= 4'h8 & tx_id[10:4] == base7 & tx_id[3:0] <= 4'h6)
    else $error("answer frame malformed");
  a_page_commit: assert property (mem_req & mem_we & mem_addr[6:0] == 7'h7F |-> mem_page_last)
    else $error("page end not committed");
  a_mem_session: assert property (mem_req |-> session_open)
    else $error("memory access without session");
  c_select: cover property (sel & hit);
  c_start: cover property (req5 & ofs == 4'h1);
  c_full_frame: cover property (tx_valid & tx_id[3:0] == 4'h3 & tx_dlc == 4'h8);
endmodule // isp_node_sva

bind isp_node isp_node_sva i_sva (.core_clk(core_clk), .rstn(rstn), .node_number(node_number),
  .identifier_base(identifier_base), .loader_version(loader_version), .prog_protect(prog_protect),
  .read_protect(read_protect), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_id(rx_id), .rx_dlc(rx_dlc),
  .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_page_last(mem_page_last), .mem_ack(mem_ack),
  .session_open(session_open));

// *** testbench/mem_model.sv ***
// Flash and EEPROM model behind the node's memory port
`timescale 1ns/100ps
module mem_model (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire        mem_area,
  input  wire [15:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  input  wire [3:0]  lat,
  input  wire        fail,
  output reg         mem_ack,
  output reg         mem_err,
  output reg  [7:0]  mem_rdata
);
  reg [7:0] mem [0:2047];
  reg [3:0] cnt;
  integer   i;
  initial for (i = 0; i < 2048; i = i + 1) mem[i] = 8'hFF;
  // Read data toggles when not acked, so stale bytes cannot match
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 8'h00;
    end else if (mem_ack | !mem_req | cnt < lat) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      cnt <= (mem_ack | !mem_req) ? 4'h0 : cnt + 4'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      mem_err <= fail & mem_we;
      if (mem_we) mem[{mem_area, mem_addr[9:0]}] <= mem_wdata;
      mem_rdata <= mem[{mem_area, mem_addr[9:0]}];
    end
  end
endmodule // mem_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the programming node
`timescale 1ns/100ps
module tb_top;
  reg         core_clk = 1'b0;
  reg         rstn = 1'b0;
  reg [7:0]   node_number = 8'h3C;
  reg [7:0]   identifier_base = 8'h25;
  reg [7:0]   loader_version = 8'hA7;
  reg         prog_protect = 1'b0, read_protect = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0, fail = 1'b0;
  reg [10:0]  rx_id = 11'h000;
  reg [3:0]   rx_dlc = 4'h0, lat = 4'h0;
  reg [63:0]  rx_data = 64'h0;
  wire        rx_ready, tx_valid, mem_req, mem_we, mem_area, mem_page_last, mem_ack, mem_err, session_open;
  wire [10:0] tx_id;
  wire [3:0]  tx_dlc;
  wire [63:0] tx_data;
  wire [15:0] mem_addr;
  wire [7:0]  mem_wdata, mem_rdata;
  integer     n_errors = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  isp_node i_dut (.core_clk(core_clk), .rstn(rstn), .node_number(node_number), .identifier_base(identifier_base),
    .loader_version(loader_version), .prog_protect(prog_protect), .read_protect(read_protect), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .mem_req(mem_req), .mem_we(mem_we), .mem_area(mem_area),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_page_last(mem_page_last), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata), .session_open(session_open));
  mem_model i_mem (.core_clk(core_clk), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we), .mem_area(mem_area),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .fail(fail), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata));
  task chk(input [63:0] got, input [63:0] want, input [8*12:1] msg);
    begin
      samples_checked = samples_checked + 1;
      if (got !== want) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t %0s got %h want %h", $time, msg, got, want);
      end
    end
  endtask
  function [63:0] pat(input [15:0] a, input [3:0] n);
    integer k;
    begin
      pat = 64'h0;
      for (k = 0; k < n; k = k + 1) pat[8*k +: 8] = (a[7:0] + k) ^ 8'h5A;
    end
  endfunction
  // Request held until taken at an edge with rx_ready high
  task send(input [3:0] ofs, input [3:0] dlc, input [63:0] d);
    integer k;
    begin
      rx_id = {identifier_base[6:0], ofs};
      rx_dlc = dlc;
      rx_data = d;
      rx_valid = 1'b1;
      k = 0;
      @(posedge core_clk);
      while (rx_ready !== 1'b1 && k < 100) begin
        @(posedge core_clk);
        k = k + 1;
      end
      #1 rx_valid = 1'b0;
    end
  endtask
  // Stalls two cycles before taking the answer
  task recv(input [3:0] ofs, input [3:0] dlc, input [63:0] d);
    integer k;
    begin
      k = 0;
      while (tx_valid !== 1'b1 && k < 400) begin
        @(posedge core_clk);
        #1 k = k + 1;
      end
      repeat (2) @(posedge core_clk);
      #1 tx_ready = 1'b1;
      @(posedge core_clk);
      chk({tx_id, tx_dlc}, {identifier_base[6:0], ofs, dlc}, "frame head");
      chk(tx_data & ~({64{1'b1}} << (8 * dlc)), d, "frame data");
      #1 tx_ready = 1'b0;
    end
  endtask
  task xfer(input [3:0] o, input [3:0] n, input [63:0] d, input [3:0] ro, input [3:0] rn, input [63:0] rd);
    begin
      send(o, n, d);
      recv(ro, rn, rd);
    end
  endtask
  task ignored(input [3:0] ofs, input [3:0] dlc, input [63:0] d);
    begin
      send(ofs, dlc, d);
      repeat (3) @(posedge core_clk);
      chk({tx_valid, rx_ready}, 2'b01, "not ignored");
      #1;
    end
  endtask
  task t_closed;
    begin
      ignored(4'h1, 4'h5, 64'h0000_0084_007C_0000);
      ignored(4'h3, 4'h5, 64'h0000_0084_007C_0000);
    end
  endtask
  task t_select;
    begin
      ignored(4'h0, 4'h1, 64'h11);
      xfer(4'h0, 4'h1, 64'h3C, 4'h0, 4'h2, 64'h01A7);
      xfer(4'h0, 4'h1, 64'hFF, 4'h0, 4'h2, 64'h00A7);
      xfer(4'h0, 4'h1, 64'hFF, 4'h0, 4'h2, 64'h01A7);
    end
  endtask
  task t_program;
    begin
      lat = 4'h3;
      prog_protect = 1'b1;
      xfer(4'h1, 4'h5, 64'h0000_0084_007C_0000, 4'h6, 4'h1, 64'h0);
      prog_protect = 1'b0;
      ignored(4'h2, 4'h1, 64'h55);
      xfer(4'h1, 4'h5, 64'h0000_0084_007C_0000, 4'h1, 4'h0, 64'h0);
      xfer(4'h2, 4'h4, pat(16'h007C, 4'h4), 4'h2, 4'h1, 64'h02);
      xfer(4'h2, 4'h5, pat(16'h0080, 4'h5), 4'h2, 4'h1, 64'h00);
      ignored(4'h2, 4'h1, 64'h55);
      lat = 4'h0;
    end
  endtask
  task t_fail;
    begin
      fail = 1'b1;
      xfer(4'h1, 4'h5, 64'h0000_0001_0000_0001, 4'h1, 4'h0, 64'h0);
      xfer(4'h2, 4'h2, 64'hBEEF, 4'h2, 4'h1, 64'h01);
      fail = 1'b0;
    end
  endtask
  task t_display;
    begin
      xfer(4'h3, 4'h5, 64'h0000_0084_007C_0000, 4'h3, 4'h8, pat(16'h007C, 4'h8));
      recv(4'h3, 4'h1, pat(16'h0084, 4'h1));
      xfer(4'h3, 4'h5, 64'h0000_0001_0000_0002, 4'h3, 4'h2, 64'hBEEF);
    end
  endtask
  task t_blank;
    begin
      xfer(4'h3, 4'h5, 64'h0000_0003_0200_0201, 4'h3, 4'h0, 64'h0);
      xfer(4'h3, 4'h5, 64'h0000_007D_007A_0001, 4'h3, 4'h2, 64'h7C00);
      read_protect = 1'b1;
      xfer(4'h3, 4'h5, 64'h0000_007D_007A_0001, 4'h6, 4'h1, 64'h0);
      read_protect = 1'b0;
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    t_closed;
    t_select;
    t_program;
    t_fail;
    t_display;
    t_blank;
    stop_test;
  end
endmodule // tb_top
